// ===== verilog/acs_pkg.sv
package acs_pkg;
  // Register indices on the plain port
  localparam logic [1:0] ADDR_CSR = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_IRQ_STAT = 2'h2;
  localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;
  // Control/status field positions
  localparam int CSR_END_FLAG = 7;
  localparam int CSR_IRQ_EN = 6;
  localparam int CSR_START = 5;
  localparam int CSR_CLK_EXT = 4;
  // Trigger/clock control field positions
  localparam int CTRL_SCAN_EN = 5;
  localparam int CTRL_SCAN_SIZE = 4;
  localparam int CTRL_CLK_HI = 3;
  localparam int CTRL_CLK_LO = 2;
  localparam int CTRL_AUTO_CLR = 1;
  // Reset values
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Default model conversion time in system cycles
  localparam int CONV_TIME_NS = 245;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_DONE = 2'h2
  } acs_state_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acs_bus_t;
endpackage

// ===== verilog/acs_ctrl.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module acs_ctrl #(
  parameter int CONV_CYC = acs_pkg::CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire acs_pkg::acs_bus_t bus_in,
  output logic [7:0] rdata,
  output logic conv_end_irq,
  output logic irq,
  output logic conv_busy,
  output logic [3:0] conv_channel,
  output logic conv_strobe,
  output logic [2:0] conv_time_sel
);
  logic end_flag_r;
  logic irq_en_r;
  logic start_r;
  logic clk_ext_r;
  logic [3:0] chan_sel_r;
  logic [7:0] ctrl_r;
  logic flag_seen_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  acs_pkg::acs_state_t state_r;
  logic [3:0] cur_ch_r;
  logic [7:0] cnt_r;
  logic pass_end;
  logic [3:0] first_ch;
  logic scan_mode;
  logic wr_csr;
  logic finish_r;
  logic auto_clr;
  logic set_flag;

  assign wr_csr = bus_in.wr && bus_in.addr == acs_pkg::ADDR_CSR;
  assign scan_mode = ctrl_r[acs_pkg::CTRL_SCAN_EN];

  // First channel of the sequence per mode
  always_comb begin
    if (!scan_mode) begin
      first_ch = chan_sel_r;
    end else if (ctrl_r[acs_pkg::CTRL_SCAN_SIZE]) begin
      first_ch = {chan_sel_r[3], 3'h0};
    end else begin
      first_ch = {chan_sel_r[3:2], 2'h0};
    end
  end

  assign pass_end = state_r == acs_pkg::ST_CONV && cnt_r == 8'h00 && cur_ch_r == chan_sel_r;
  // Auto clear in single mode or scan with auto clear, a cycle before the flag
  assign auto_clr = pass_end && (!scan_mode || ctrl_r[acs_pkg::CTRL_AUTO_CLR]);
  assign set_flag = finish_r;

  // Delayed pass end marks the flag set one cycle after start clears
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      finish_r <= 1'b0;
    end else begin
      finish_r <= pass_end;
    end
  end

  // Read-of-one tracking for the end flag clear handshake
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_seen_r <= 1'b0;
    end else if (bus_in.rd && bus_in.addr == acs_pkg::ADDR_CSR && end_flag_r) begin
      flag_seen_r <= 1'b1;
    end else if (wr_csr && !bus_in.wdata[acs_pkg::CSR_END_FLAG]) begin
      flag_seen_r <= 1'b0;
    end
  end

  // End flag: set wins over clear so no completion is lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      end_flag_r <= 1'b0;
    end else if (set_flag) begin
      end_flag_r <= 1'b1;
    end else if (wr_csr && !bus_in.wdata[acs_pkg::CSR_END_FLAG] && flag_seen_r) begin
      end_flag_r <= 1'b0;
    end
  end

  // Software fields of the control/status register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_en_r <= 1'b0;
      clk_ext_r <= 1'b0;
      chan_sel_r <= 4'h0;
    end else if (wr_csr) begin
      irq_en_r <= bus_in.wdata[acs_pkg::CSR_IRQ_EN];
      clk_ext_r <= bus_in.wdata[acs_pkg::CSR_CLK_EXT];
      chan_sel_r <= bus_in.wdata[3:0];
    end
  end

  // Start bit: software write beats the automatic clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      start_r <= 1'b0;
    end else if (wr_csr) begin
      start_r <= bus_in.wdata[acs_pkg::CSR_START];
    end else if (auto_clr) begin
      start_r <= 1'b0;
    end
  end

  // Trigger/clock control register, all eight bits written, reserved bit 0 included
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= acs_pkg::CTRL_RESET;
    end else if (bus_in.wr && bus_in.addr == acs_pkg::ADDR_CTRL) begin
      ctrl_r <= bus_in.wdata;
    end
  end

  // Conversion sequencer; the counter models conversion time only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= acs_pkg::ST_IDLE;
      cur_ch_r <= 4'h0;
      cnt_r <= 8'h00;
    end else if (!start_r || (wr_csr && !bus_in.wdata[acs_pkg::CSR_START])) begin
      state_r <= acs_pkg::ST_IDLE;
    end else begin
      case (state_r)
        acs_pkg::ST_IDLE: begin
          state_r <= acs_pkg::ST_CONV;
          cur_ch_r <= first_ch;
          cnt_r <= 8'(CONV_CYC - 1);
        end
        acs_pkg::ST_CONV: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (auto_clr) begin
            state_r <= acs_pkg::ST_DONE;
          end else begin
            // Ascending order, wrap to the lowest selected channel
            cur_ch_r <= (cur_ch_r == chan_sel_r) ? first_ch : cur_ch_r + 4'h1;
            cnt_r <= 8'(CONV_CYC - 1);
          end
        end
        acs_pkg::ST_DONE: begin
          state_r <= acs_pkg::ST_IDLE;
        end
        default: begin
          state_r <= acs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Interrupt status (bit0 end event), write one to clear, set wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stat_r <= 2'h0;
      mask_r <= 2'h0;
    end else begin
      if (bus_in.wr && bus_in.addr == acs_pkg::ADDR_IRQ_MASK) begin
        mask_r <= bus_in.wdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && set_flag) || (i == 1 && auto_clr)) begin
          stat_r[i] <= 1'b1;
        end else if (bus_in.wr && bus_in.addr == acs_pkg::ADDR_IRQ_STAT && bus_in.wdata[i]) begin
          stat_r[i] <= 1'b0;
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      conv_end_irq <= 1'b0;
      irq <= 1'b0;
      conv_busy <= 1'b0;
      conv_channel <= 4'h0;
      conv_strobe <= 1'b0;
      conv_time_sel <= 3'h0;
    end else begin
      conv_end_irq <= end_flag_r && irq_en_r;
      irq <= |(stat_r & mask_r);
      conv_busy <= state_r == acs_pkg::ST_CONV;
      conv_channel <= cur_ch_r;
      conv_strobe <= state_r == acs_pkg::ST_CONV && cnt_r == 8'h00;
      conv_time_sel <= {clk_ext_r, ctrl_r[acs_pkg::CTRL_CLK_HI], ctrl_r[acs_pkg::CTRL_CLK_LO]};
      rdata <= 8'h00;
      if (bus_in.rd) begin
        case (bus_in.addr)
          acs_pkg::ADDR_CSR: rdata <= {end_flag_r, irq_en_r, start_r, clk_ext_r, chan_sel_r};
          acs_pkg::ADDR_CTRL: rdata <= ctrl_r;
          acs_pkg::ADDR_IRQ_STAT: rdata <= {6'h00, stat_r};
          acs_pkg::ADDR_IRQ_MASK: rdata <= {6'h00, mask_r};
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(end_flag_r) |-> $past(wr_csr) && $past(flag_seen_r)) else $error("end flag cleared without read-then-write0");
  flag_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    end_flag_r && wr_csr && bus_in.wdata[acs_pkg::CSR_END_FLAG] |=> end_flag_r) else $error("write 1 changed end flag");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 conv_end_irq == $past(end_flag_r && irq_en_r)) else $error("interrupt request mismatch");
  stop_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_csr && !bus_in.wdata[acs_pkg::CSR_START] |=> state_r == acs_pkg::ST_IDLE && !start_r) else $error("stop did not idle");
  start_go_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_csr && bus_in.wdata[acs_pkg::CSR_START] && state_r == acs_pkg::ST_IDLE |=> ##1 state_r == acs_pkg::ST_CONV)
    else $error("start did not begin conversion");
  single_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pass_end && !scan_mode && !wr_csr |=> !start_r) else $error("single mode kept start");
  scan_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pass_end && scan_mode && !ctrl_r[acs_pkg::CTRL_AUTO_CLR] && !wr_csr |=> start_r && cur_ch_r == first_ch)
    else $error("scan did not repeat");
  scan_auto_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pass_end && scan_mode && ctrl_r[acs_pkg::CTRL_AUTO_CLR] && !wr_csr |=> !start_r) else $error("auto clear missed");
  sequence s_clr;
    auto_clr && !wr_csr;
  endsequence
  clr_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_clr |=> !start_r && !$past(set_flag) ##0 set_flag) else $error("start not cleared before flag");

  // Sequencer about to leave idle with no stop write in the way
  sequence s_launch;
    state_r == acs_pkg::ST_IDLE && start_r && !wr_csr;
  endsequence
  // Channel finished below the top of the range, so the sequencer steps up
  sequence s_step;
    state_r == acs_pkg::ST_CONV && cnt_r == 8'h00 && cur_ch_r != chan_sel_r && start_r && !wr_csr;
  endsequence
  // A completed pass always lands in the end flag
  flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    finish_r |=> end_flag_r)
    else $error("end flag not set after pass");
  // Nothing but the read-then-write-0 handshake drops the flag
  flag_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    end_flag_r && !(wr_csr && !bus_in.wdata[acs_pkg::CSR_END_FLAG] && flag_seen_r) |=> end_flag_r)
    else $error("end flag dropped without handshake");
  // The flag only rises from a completion, never from a write
  flag_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(end_flag_r) |-> $past(finish_r))
    else $error("end flag rose without completion");
  // A write of 0 spends the read token, so a second write needs a new read
  seen_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_csr && !bus_in.wdata[acs_pkg::CSR_END_FLAG] && !bus_in.rd |=> !flag_seen_r)
    else $error("read token kept after write 0");
  // A read that sees the flag set arms the clear
  seen_arm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_in.rd && bus_in.addr == acs_pkg::ADDR_CSR && end_flag_r |=> flag_seen_r)
    else $error("read of set flag not recorded");
  // With the enable low the request stays quiet whatever the flag does
  irq_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !irq_en_r |=> !conv_end_irq)
    else $error("interrupt request while disabled");
  // Automatic start clear is recorded as its own event
  stat_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    auto_clr |=> stat_r[1])
    else $error("auto clear event lost");
  // End event is recorded; set wins over a clear in the same cycle
  stat_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    set_flag |=> stat_r[0])
    else $error("end event lost");
  // Status reads return the live fields one cycle later
  csr_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_in.rd && bus_in.addr == acs_pkg::ADDR_CSR |=> rdata == $past({end_flag_r, irq_en_r, start_r, clk_ext_r, chan_sel_r}))
    else $error("status read mismatch");
  // Event status reads return the sticky bits
  stat_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_in.rd && bus_in.addr == acs_pkg::ADDR_IRQ_STAT |=> rdata == {6'h00, $past(stat_r)})
    else $error("event status read mismatch");
  // Single mode converts the coded channel itself
  single_ch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_launch ##0 !scan_mode |=> cur_ch_r == chan_sel_r)
    else $error("single mode channel wrong");
  // Four-channel scan starts at the base of the coded group of four
  four_base_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_launch ##0 scan_mode && !ctrl_r[acs_pkg::CTRL_SCAN_SIZE] |=> cur_ch_r == {chan_sel_r[3:2], 2'h0})
    else $error("four-channel scan base wrong");
  // Eight-channel scan starts at 0 or at 8
  eight_base_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_launch ##0 scan_mode && ctrl_r[acs_pkg::CTRL_SCAN_SIZE] |=> cur_ch_r == {chan_sel_r[3], 3'h0})
    else $error("eight-channel scan base wrong");
  // Leaving idle loads a full conversion time
  launch_conv_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_launch |=> state_r == acs_pkg::ST_CONV && cnt_r == 8'(CONV_CYC - 1))
    else $error("conversion not launched");
  // Channels advance by one inside the range
  step_up_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_step |=> cur_ch_r == $past(cur_ch_r) + 4'h1)
    else $error("scan did not step up");
  // The converted channel never leaves the selected range
  ch_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == acs_pkg::ST_CONV |-> cur_ch_r >= first_ch && cur_ch_r <= chan_sel_r)
    else $error("channel outside selected range");
  // Single mode never wanders off the coded channel
  single_stay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == acs_pkg::ST_CONV && !scan_mode |-> cur_ch_r == chan_sel_r)
    else $error("single mode left its channel");
  // Conversion time counts down one per cycle
  cnt_down_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == acs_pkg::ST_CONV && cnt_r != 8'h00 && start_r && !wr_csr |=> cnt_r == $past(cnt_r) - 8'h01)
    else $error("conversion timer stalled");
  // With start low the sequencer sits in idle
  stop_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !start_r |=> state_r == acs_pkg::ST_IDLE)
    else $error("sequencer ran with start low");
  // Busy output follows the idle state
  idle_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == acs_pkg::ST_IDLE |=> !conv_busy)
    else $error("busy while idle");
  // The done state lasts one cycle only
  done_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == acs_pkg::ST_DONE |=> state_r == acs_pkg::ST_IDLE)
    else $error("done state stuck");
  // Clock select output tracks all three bits together
  time_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 conv_time_sel == $past({clk_ext_r, ctrl_r[acs_pkg::CTRL_CLK_HI], ctrl_r[acs_pkg::CTRL_CLK_LO]}))
    else $error("time select mismatch");
  // Continuous scan keeps start set until software stops it
  scan_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    scan_mode && !ctrl_r[acs_pkg::CTRL_AUTO_CLR] && start_r && !wr_csr |=> start_r)
    else $error("continuous scan lost start");
  // A write of 1 to start is taken at once
  start_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_csr && bus_in.wdata[acs_pkg::CSR_START] |=> start_r)
    else $error("start write not taken");
  // Start only falls by a software write or the automatic clear
  start_fall_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(start_r) |-> $past(wr_csr) || $past(auto_clr))
    else $error("start fell without cause");
  // A strobe marks exactly one finished channel conversion
  strobe_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    conv_strobe |-> $past(state_r == acs_pkg::ST_CONV && cnt_r == 8'h00))
    else $error("strobe without finished conversion");
endmodule

// ===== dv/adc_control_status_logic_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module adc_control_status_logic_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  acs_pkg::acs_bus_t bus_in = '0;
  logic [7:0] rdata;
  logic conv_end_irq, irq, conv_busy, conv_strobe;
  logic [3:0] conv_channel;
  logic [2:0] conv_time_sel;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] d;
  logic [7:0] modes [6] = '{8'h00, 8'h10, 8'h22, 8'h32, 8'h20, 8'h30};
  // Short conversion time keeps full scan_size_bit well inside the run limit
  acs_ctrl #(.CONV_CYC(3)) acs_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus_in(bus_in), .rdata(rdata),
    .conv_end_irq(conv_end_irq), .irq(irq), .conv_busy(conv_busy), .conv_channel(conv_channel),
    .conv_strobe(conv_strobe), .conv_time_sel(conv_time_sel));
  always #2.5 clk_sys = ~clk_sys;
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One-cycle write strobe; a cycle of gap follows
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_in.addr <= a;
    bus_in.wdata <= v;
    bus_in.wr <= 1'b1;
    @(posedge clk_sys);
    bus_in.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys);
    bus_in.addr <= a;
    bus_in.rd <= 1'b1;
    @(posedge clk_sys);
    bus_in.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_strobe(output logic [3:0] c);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (conv_strobe !== 1'b1 && n < 200);
    `CHK("strobe", 1'b1, conv_strobe)
    c = conv_channel;
  endtask
  // Reference model of the first channel of a sequence
  function automatic logic [3:0] lo_of(input logic [7:0] m, input logic [3:0] c);
    if (!m[acs_pkg::CTRL_SCAN_EN]) return c;
    return m[acs_pkg::CTRL_SCAN_SIZE] ? {c[3], 3'h0} : {c[3:2], 2'h0};
  endfunction
  task automatic run(input logic [7:0] m, input logic [7:0] mask);
    logic [3:0] c, lo, got;
    logic [7:0] st;
    logic e, cont;
    int span;
    c = 4'($urandom % 12);
    e = 1'($urandom);
    m = m | 8'($urandom & 8'h0C);
    lo = lo_of(m, c);
    span = int'(c) - int'(lo) + 1;
    cont = m[acs_pkg::CTRL_SCAN_EN] & ~m[acs_pkg::CTRL_AUTO_CLR];
    st = cont ? 8'h01 : 8'h03;
    wr(acs_pkg::ADDR_IRQ_MASK, mask);
    wr(acs_pkg::ADDR_CTRL, m);
    wr(acs_pkg::ADDR_CSR, {3'h3, e, c}); // Channel is taken on every CSR write, whatever start reads
    // The time select output is registered one cycle behind the fields
    @(posedge clk_sys);
    #1;
    `CHK("time_sel", {e, m[3:2]}, conv_time_sel)
    for (int i = 0; i < (cont ? 2 * span + 1 : span); i++) begin
      wait_strobe(got);
      `CHK("channel", 4'(lo + 4'(i % span)), got)
    end
    if (cont) begin
      wr(acs_pkg::ADDR_CSR, {3'h2, e, c});
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("busy", 1'b0, conv_busy)
    end
    repeat (4) @(posedge clk_sys);
    // A write of 0 with no read of the set flag first must not clear it
    wr(acs_pkg::ADDR_CSR, {3'h2, e, c});
    rd(acs_pkg::ADDR_CSR);
    `CHK("csr", {3'h6, e, c}, d)
    `CHK("end_irq", 1'b1, conv_end_irq)
    rd(acs_pkg::ADDR_IRQ_STAT);
    `CHK("stat", st, d)
    `CHK("irq", |(st & mask), irq)
    wr(acs_pkg::ADDR_CSR, {3'h6, e, c});
    rd(acs_pkg::ADDR_CSR);
    `CHK("flag_kept", {3'h6, e, c}, d)
    wr(acs_pkg::ADDR_CSR, {3'h2, e, c});
    rd(acs_pkg::ADDR_CSR);
    `CHK("flag_clr", {3'h2, e, c}, d)
    `CHK("end_irq_off", 1'b0, conv_end_irq)
    wr(acs_pkg::ADDR_IRQ_STAT, 8'h03);
    rd(acs_pkg::ADDR_IRQ_STAT);
    `CHK("stat_clr", 8'h00, d)
    `CHK("irq_off", 1'b0, irq)
  endtask
  initial begin
    void'($urandom(81319));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(acs_pkg::ADDR_CSR);
    `CHK("csr_rst", acs_pkg::CSR_RESET, d)
    rd(acs_pkg::ADDR_CTRL);
    `CHK("ctrl_rst", acs_pkg::CTRL_RESET, d)
    // Each mode twice, masked only in run 1, to reach both interrupt paths
    for (int t = 0; t < 12; t++) begin
      run(modes[t % 6], (t == 1) ? 8'h00 : 8'h03);
      $display("test %0d done", t);
    end
    report_and_stop();
  end
endmodule
